// *** dv/apb_host.sv ***
// Host-side APB master model that drives register transfers into the bank.
`default_nettype none

module apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus; released address and data lines show inverted stale values so nothing passes by luck.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'hFFFFFFFF;
        pstrb = 4'h0;
    end

    // One transfer; the request is held until pready is sampled high or 16 access cycles pass, never assumed.
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
            input logic [3:0] strb, output logic [31:0] rdata, output logic err,
            output logic ok);
        int n;
        ok = 1'b0;
        rdata = 32'h0;
        err = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                rdata = prdata;
                err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wdata;
    endtask
endmodule

`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the channel calibration and configuration register bank.
`default_nettype none

module testbench
    import cal_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, glob_dc = 1'b1, err, ovr, dca;
    logic pins, shrt, tst, neg;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [15:0] crc = 16'h0000;
    logic [23:0] o2, g2, o3, g3;
    logic [9:0] ph;
    logic [1:0] sel, kk;
    int mismatches = 0;
    int checks = 0;

    typedef struct packed {
        logic [7:0] a;
        logic [15:0] rst;
        logic [15:0] wd;
        logic [15:0] rb;
    } row_t;
    // Address, reset value, written value and the value it must read back as.
    localparam row_t ROWS [10] = '{
        '{8'h50, 16'h0000, 16'h1234, 16'h1234}, '{8'h54, 16'h0000, 16'hABCD, 16'hAB00},
        '{8'h58, 16'h8000, 16'h7FFF, 16'h7FFF}, '{8'h5C, 16'h0000, 16'h5AFF, 16'h5A00},
        '{8'h60, 16'h0000, 16'hFFFF, 16'hFFC7}, '{8'h64, 16'h0000, 16'hCAFE, 16'hCAFE},
        '{8'h68, 16'h0000, 16'h3CFF, 16'h3C00}, '{8'h6C, 16'h8000, 16'h8001, 16'h8001},
        '{8'h70, 16'h0000, 16'hFF11, 16'hFF00}, '{8'hF8, 16'h0000, 16'hFFFF, 16'h0000}};

    // Free-running 125 MHz clock.
    always #4 pclk = ~pclk;

    apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    channel_cal_config_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_dc_block_setting(glob_dc), .register_map_checksum_value(crc), .ch2_offset_value(o2),
        .ch2_gain_value(g2), .ch3_offset_value(o3), .ch3_gain_value(g3),
        .ch3_phase_delay(ph), .ch3_dc_block_override(ovr), .ch3_dc_block_active(dca),
        .ch3_input_select(sel), .ch3_pins_connected(pins), .ch3_inputs_shorted(shrt),
        .ch3_test_signal_on(tst), .ch3_test_signal_negative(neg));

    task automatic end_sim();
        if (mismatches == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // A transfer that never completes ends the run at once as a failure.
    task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d,
            input logic [3:0] s);
        logic ok;
        host.xfer(wr, a, {16'h0000, d}, s, rd, err, ok);
        if (!ok) begin
            mismatches++;
            $display("[ERR] %0t transfer timed out", $time);
            end_sim();
        end
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset value, write, then readback with reserved bits forced to zero.
        foreach (ROWS[i]) begin
            acc(1'b0, ROWS[i].a, 16'h0, 4'h0);
            check(rd, {16'h0, ROWS[i].rst});
            acc(1'b1, ROWS[i].a, ROWS[i].wd, 4'hF);
            acc(1'b0, ROWS[i].a, 16'h0, 4'h0);
            check(rd, {16'h0, ROWS[i].rb});
        end
        check({8'h0, o2}, 32'h1234AB);
        check({8'h0, g2}, 32'h7FFF5A);
        check({8'h0, o3}, 32'hCAFE3C);
        check({8'h0, g3}, 32'h8001FF);
        // Every input selection code, with the DC-block override toggled alongside.
        for (int k = 0; k < 4; k++) begin
            kk = k[1:0];
            acc(1'b1, 8'h60, {10'h200, 3'b000, kk[0], kk}, 4'hF);
            repeat (2) @(posedge pclk);
            check({20'h0, ph, sel}, {20'h0, 10'h200, kk});
            check({30'h0, ovr, dca}, {30'h0, kk[0], ~kk[0]});
            check({28'h0, pins, shrt, tst, neg},
                {28'h0, kk == 2'd0, kk == 2'd1, kk[1], kk == 2'd3});
        end
        // Only byte lane 0 is strobed; the upper byte must keep its value.
        acc(1'b1, 8'h50, 16'hFFFF, 4'h1);
        acc(1'b0, 8'h50, 16'h0, 4'h0);
        check(rd, 32'h12FF);
        // Unmapped and unaligned accesses are refused and change nothing.
        acc(1'b0, 8'h74, 16'h0, 4'h0);
        check({rd[30:0], err}, 32'h1);
        acc(1'b1, 8'h52, 16'h5555, 4'hF);
        check({31'h0, err}, 32'h1);
        acc(1'b0, 8'h50, 16'h0, 4'h0);
        check(rd, 32'h12FF);
        // The checksum word follows its source and ignores writes without an error.
        crc <= 16'h5A3C;
        acc(1'b1, 8'hF8, 16'h1111, 4'hF);
        check({31'h0, err}, 32'h0);
        acc(1'b0, 8'hF8, 16'h0, 4'h0);
        check(rd, 32'h5A3C);
        check({31'h0, err}, 32'h0);
        // A reset in mid-run restores the calibration defaults.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check({8'h0, g3}, 32'h800000);
        check({22'h0, ph}, 32'h0);
        check({8'h0, o2}, 32'h0);
        check({8'h0, o3}, 32'h0);
        presetn <= 1'b1;
        acc(1'b0, 8'h58, 16'h0, 4'h0);
        check(rd, {16'h0, RST_GAIN_HIGH});
        // With the override clear, channel 3 follows the global DC-block setting.
        glob_dc <= 1'b0;
        repeat (2) @(posedge pclk);
        check({31'h0, dca}, 32'h0);
        glob_dc <= 1'b1;
        repeat (2) @(posedge pclk);
        check({31'h0, dca}, 32'h1);
        end_sim();
    end
endmodule

`default_nettype wire

// *** hdl/cal_reg16.sv ***
// One 16-bit register with a reset value and a mask of writable bits.
`default_nettype none

module cal_reg16
    import cal_regs_pkg::*;
#(
    parameter logic [15:0] RESET_VALUE = 16'h0000,
    parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [REG_W-1:0] wr_data,
    output logic [REG_W-1:0] value
);

    logic [REG_W-1:0] value_q;
    logic [REG_W-1:0] value_d;

    // Reserved bits are masked on the way in, so they can never hold a one.
    assign value_d = wr_en ? (wr_data & WRITE_MASK) : value_q;
    assign value = value_q;

    // Storage flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= RESET_VALUE;
        end else begin
            value_q <= value_d;
        end
    end

    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (value_q & ~WRITE_MASK) == 16'h0000)
        else $error("Reserved register bits hold a one.");

endmodule

`default_nettype wire

// *** hdl/cal_regs_pkg.sv ***
// Package with the register map, field layout and reset values of the calibration bank.
`default_nettype none

package cal_regs_pkg;

    // Bus and storage widths.
    localparam int APB_ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int CAL_W = 24;
    localparam int NUM_SLOTS = 9;

    // Register indices; the byte address of each register is four times its index.
    localparam logic [5:0] IDX_CH2_OFFSET_CAL_HIGH = 6'h14;
    localparam logic [5:0] IDX_CH2_OFFSET_CAL_LOW = 6'h15;
    localparam logic [5:0] IDX_CH2_GAIN_CAL_HIGH = 6'h16;
    localparam logic [5:0] IDX_CH2_GAIN_CAL_LOW = 6'h17;
    localparam logic [5:0] IDX_CH3_CONFIG_WORD = 6'h18;
    localparam logic [5:0] IDX_CH3_OFFSET_CAL_HIGH = 6'h19;
    localparam logic [5:0] IDX_CH3_OFFSET_CAL_LOW = 6'h1A;
    localparam logic [5:0] IDX_CH3_GAIN_CAL_HIGH = 6'h1B;
    localparam logic [5:0] IDX_CH3_GAIN_CAL_LOW = 6'h1C;
    localparam logic [5:0] IDX_REGISTER_MAP_CHECKSUM = 6'h3E;

    // Storage slots of the writable registers, in ascending index order.
    localparam int SLOT_CH2_OFS_HI = 0;
    localparam int SLOT_CH2_OFS_LO = 1;
    localparam int SLOT_CH2_GAIN_HI = 2;
    localparam int SLOT_CH2_GAIN_LO = 3;
    localparam int SLOT_CH3_CONFIG_WORD = 4;
    localparam int SLOT_CH3_OFS_HI = 5;
    localparam int SLOT_CH3_OFS_LO = 6;
    localparam int SLOT_CH3_GAIN_HI = 7;
    localparam int SLOT_CH3_GAIN_LO = 8;

    // Reset values.
    localparam logic [15:0] RST_OFFSET = 16'h0000;
    localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;
    localparam logic [15:0] RST_LOW = 16'h0000;
    localparam logic [15:0] RST_CONFIG = 16'h0000;
    localparam logic [15:0] RST_CHECKSUM = 16'h0000;

    // Writable bit masks; cleared bits are reserved and read as zero.
    localparam logic [15:0] MASK_HIGH = 16'hFFFF;
    localparam logic [15:0] MASK_LOW = 16'hFF00;
    localparam logic [15:0] MASK_CONFIG = 16'hFFC7;

    localparam logic [5:0] SLOT_INDEX [NUM_SLOTS] = '{
        IDX_CH2_OFFSET_CAL_HIGH, IDX_CH2_OFFSET_CAL_LOW, IDX_CH2_GAIN_CAL_HIGH,
        IDX_CH2_GAIN_CAL_LOW, IDX_CH3_CONFIG_WORD, IDX_CH3_OFFSET_CAL_HIGH,
        IDX_CH3_OFFSET_CAL_LOW, IDX_CH3_GAIN_CAL_HIGH, IDX_CH3_GAIN_CAL_LOW};
    localparam logic [15:0] SLOT_RESET [NUM_SLOTS] = '{
        RST_OFFSET, RST_LOW, RST_GAIN_HIGH, RST_LOW, RST_CONFIG,
        RST_OFFSET, RST_LOW, RST_GAIN_HIGH, RST_LOW};
    localparam logic [15:0] SLOT_MASK [NUM_SLOTS] = '{
        MASK_HIGH, MASK_LOW, MASK_HIGH, MASK_LOW, MASK_CONFIG,
        MASK_HIGH, MASK_LOW, MASK_HIGH, MASK_LOW};

    // Field positions in the channel 3 configuration word and low registers.
    localparam int PHASE_MSB = 15;
    localparam int PHASE_LSB = 6;
    localparam int DC_OVERRIDE_BIT = 2;
    localparam int SEL_MSB = 1;
    localparam int SEL_LSB = 0;
    localparam int LOW_FIELD_MSB = 15;
    localparam int LOW_FIELD_LSB = 8;

    // Converter input selection codes.
    typedef enum logic [1:0] {
        SEL_PIN_PAIR = 2'b00,
        SEL_SHORTED = 2'b01,
        SEL_TEST_POS = 2'b10,
        SEL_TEST_NEG = 2'b11
    } input_sel_t;

endpackage

`default_nettype wire

// *** hdl/channel_cal_config_regs.sv ***
// APB register bank for channel 2 and 3 calibration, channel 3 configuration and checksum.
//
// What this block does
// - Offset high register holds offset correction bits 23 to 8 in all 16 bits.
// - Offset low register holds offset correction bits 7 to 0 in its upper byte.
// - Lower byte of every calibration low register is read-only and reads zero.
// - Gain high register holds gain correction bits 23 to 8.
// - Gain low register holds gain correction bits 7 to 0 in bits 15 to 8.
// - Gain high resets to 8000h, gain low resets to zero.
// - Offset registers reset to 0000h, meaning no offset correction.
// - Config bits 15 to 6 are a signed phase delay, reset zero.
// - Config bit 2 set disables DC blocking for channel 3, else global setting.
// - Config bits 1 to 0 select pins, shorted, positive or negative test signal.
// - Config bits 5 to 3 are read-only and read 000b.
// - Register-map checksum word sits at index 3Eh, resets to zero, then tracks register_map_checksum_value each cycle.
`default_nettype none

module channel_cal_config_regs
    import cal_regs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic global_dc_block_setting,
    input wire logic [REG_W-1:0] register_map_checksum_value,
    output logic [CAL_W-1:0] ch2_offset_value,
    output logic [CAL_W-1:0] ch2_gain_value,
    output logic [CAL_W-1:0] ch3_offset_value,
    output logic [CAL_W-1:0] ch3_gain_value,
    output logic signed [PHASE_MSB-PHASE_LSB:0] ch3_phase_delay,
    output logic ch3_dc_block_override,
    output logic ch3_dc_block_active,
    output logic [1:0] ch3_input_select,
    output logic ch3_pins_connected,
    output logic ch3_inputs_shorted,
    output logic ch3_test_signal_on,
    output logic ch3_test_signal_negative
);

    logic [5:0] word_index;
    logic aligned;
    logic [NUM_SLOTS-1:0] slot_hit;
    logic [NUM_SLOTS-1:0] slot_wr;
    logic [REG_W-1:0] slot_value [NUM_SLOTS];
    logic [REG_W-1:0] slot_wdata [NUM_SLOTS];
    logic [REG_W-1:0] lane_mask;
    logic crc_hit;
    logic addr_hit;
    logic access_wait;
    logic transfer_done;
    logic wr_fire;
    logic [REG_W-1:0] rd_value;
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [REG_W-1:0] crc_q;
    logic dc_active_q;
    logic dc_active_d;
    logic pins_q;
    logic pins_d;
    logic shorted_q;
    logic shorted_d;
    logic test_on_q;
    logic test_on_d;
    logic test_neg_q;
    logic test_neg_d;
    logic [REG_W-1:0] cfg;
    input_sel_t sel;

    // Address decode: only word-aligned addresses match a register.
    assign word_index = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign crc_hit = aligned && (word_index == IDX_REGISTER_MAP_CHECKSUM);
    assign addr_hit = (|slot_hit) || crc_hit;

    // APB phases; one wait state gives the read mux a full cycle.
    assign access_wait = psel && penable && !pready_q;
    assign transfer_done = psel && penable && pready_q;
    assign wr_fire = transfer_done && pwrite;

    // Byte lanes 0 and 1 carry the 16-bit registers; lanes 2 and 3 are ignored.
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Storage and write steering, one register per slot.
    generate
        for (genvar g = 0; g < NUM_SLOTS; g++) begin : gen_slot
            assign slot_hit[g] = aligned && (word_index == SLOT_INDEX[g]);
            assign slot_wr[g] = wr_fire && slot_hit[g];
            assign slot_wdata[g] = (pwdata[REG_W-1:0] & lane_mask)
                | (slot_value[g] & ~lane_mask);
            cal_reg16 #(
                .RESET_VALUE(SLOT_RESET[g]),
                .WRITE_MASK(SLOT_MASK[g])
            ) u_reg (
                .pclk(pclk),
                .presetn(presetn),
                .wr_en(slot_wr[g]),
                .wr_data(slot_wdata[g]),
                .value(slot_value[g])
            );
        end
    endgenerate

    // Read mux; a miss reads zero and is flagged as a slave error.
    always_comb begin
        rd_value = crc_hit ? crc_q : 16'h0000;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (slot_hit[i]) begin
                rd_value = rd_value | slot_value[i];
            end
        end
    end

    // Answer signals are all computed in the wait cycle and stand for one cycle.
    assign pready_d = access_wait;
    assign pslverr_d = access_wait && !addr_hit;
    assign prdata_d = (access_wait && !pwrite) ? {16'h0000, rd_value} : 32'h0000_0000;

    // Bus answer flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // Checksum holder; the checksum engine lives elsewhere, bus writes do not touch it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_q <= RST_CHECKSUM;
        end else begin
            crc_q <= register_map_checksum_value;
        end
    end

    // Correction words: high register on top, upper byte of low register below.
    assign ch2_offset_value = {slot_value[SLOT_CH2_OFS_HI],
        slot_value[SLOT_CH2_OFS_LO][LOW_FIELD_MSB:LOW_FIELD_LSB]};
    assign ch2_gain_value = {slot_value[SLOT_CH2_GAIN_HI],
        slot_value[SLOT_CH2_GAIN_LO][LOW_FIELD_MSB:LOW_FIELD_LSB]};
    assign ch3_offset_value = {slot_value[SLOT_CH3_OFS_HI],
        slot_value[SLOT_CH3_OFS_LO][LOW_FIELD_MSB:LOW_FIELD_LSB]};
    assign ch3_gain_value = {slot_value[SLOT_CH3_GAIN_HI],
        slot_value[SLOT_CH3_GAIN_LO][LOW_FIELD_MSB:LOW_FIELD_LSB]};

    // Channel 3 configuration fields.
    assign cfg = slot_value[SLOT_CH3_CONFIG_WORD];
    assign ch3_phase_delay = cfg[PHASE_MSB:PHASE_LSB];
    assign ch3_dc_block_override = cfg[DC_OVERRIDE_BIT];
    assign ch3_input_select = cfg[SEL_MSB:SEL_LSB];
    assign sel = input_sel_t'(cfg[SEL_MSB:SEL_LSB]);

    // The override only ever turns blocking off; it cannot force it on.
    assign dc_active_d = global_dc_block_setting && !cfg[DC_OVERRIDE_BIT];

    // Input routing decode for the front end.
    always_comb begin
        pins_d = 1'b0;
        shorted_d = 1'b0;
        test_on_d = 1'b0;
        test_neg_d = 1'b0;
        case (sel)
            SEL_PIN_PAIR: begin
                pins_d = 1'b1;
            end
            SEL_SHORTED: begin
                shorted_d = 1'b1;
            end
            SEL_TEST_POS: begin
                test_on_d = 1'b1;
            end
            SEL_TEST_NEG: begin
                test_on_d = 1'b1;
                test_neg_d = 1'b1;
            end
            default: begin
                pins_d = 1'b1;
            end
        endcase
    end

    // Routing flops; resetting to the pin pair matches the reset select code.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dc_active_q <= 1'b0;
            pins_q <= 1'b1;
            shorted_q <= 1'b0;
            test_on_q <= 1'b0;
            test_neg_q <= 1'b0;
        end else begin
            dc_active_q <= dc_active_d;
            pins_q <= pins_d;
            shorted_q <= shorted_d;
            test_on_q <= test_on_d;
            test_neg_q <= test_neg_d;
        end
    end

    // Port drivers.
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign ch3_dc_block_active = dc_active_q;
    assign ch3_pins_connected = pins_q;
    assign ch3_inputs_shorted = shorted_q;
    assign ch3_test_signal_on = test_on_q;
    assign ch3_test_signal_negative = test_neg_q;

    // Checks on the bank's behaviour.
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence read_wait_s(logic [5:0] idx);
        access_wait && !pwrite && aligned && (word_index == idx);
    endsequence

    sequence write_done_s(logic [5:0] idx);
        wr_fire && aligned && (word_index == idx) && (pstrb[1:0] == 2'b11);
    endsequence

    apb_answer_a: assert property (access_wait |=> pready_q && !access_wait)
        else $error("Slave did not answer after one wait state.");

    // The answer is a one-cycle pulse; read data falls back to zero with it.
    answer_pulse_a: assert property (pready_q |=> !pready_q && prdata_q == 32'h0000_0000)
        else $error("Bus answer stood for more than one cycle.");

    miss_error_a: assert property (access_wait && !addr_hit |=> pslverr_q && pready_q)
        else $error("Unmapped access was not flagged with the answer.");

    upper_half_a: assert property (prdata_q[31:16] == 16'h0000)
        else $error("Upper half of the read data is not zero.");

    gain_reset_a: assert property ($rose(presetn) |->
        ch2_gain_value == 24'h800000 && ch3_gain_value == 24'h800000)
        else $error("Gain correction is not 800000h after reset.");

    offset_reset_a: assert property ($rose(presetn) |->
        ch2_offset_value == 24'h000000 && ch3_offset_value == 24'h000000)
        else $error("Offset correction is not zero after reset.");

    low_reserved_a: assert property (read_wait_s(IDX_CH3_GAIN_CAL_LOW) |=>
        prdata_q[7:0] == 8'h00)
        else $error("Reserved low byte did not read zero.");

    cfg_reserved_a: assert property (read_wait_s(IDX_CH3_CONFIG_WORD) |=>
        prdata_q[5:3] == 3'b000)
        else $error("Reserved configuration bits did not read zero.");

    offset_high_join_a: assert property (write_done_s(IDX_CH2_OFFSET_CAL_HIGH) |=>
        ch2_offset_value[23:8] == $past(pwdata[15:0]))
        else $error("Offset high word not applied to the correction value.");

    offset_low_join_a: assert property (write_done_s(IDX_CH3_OFFSET_CAL_LOW) |=>
        ch3_offset_value[7:0] == $past(pwdata[15:8]))
        else $error("Offset low byte not applied to the correction value.");

    gain_high_join_a: assert property (write_done_s(IDX_CH2_GAIN_CAL_HIGH) |=>
        ch2_gain_value[23:8] == $past(pwdata[15:0]))
        else $error("Gain high word not applied to the correction value.");

    gain_low_join_a: assert property (write_done_s(IDX_CH2_GAIN_CAL_LOW) |=>
        ch2_gain_value[7:0] == $past(pwdata[15:8]))
        else $error("Gain low byte not applied to the correction value.");

    cfg_fields_a: assert property (write_done_s(IDX_CH3_CONFIG_WORD) |=>
        ch3_phase_delay == $past(pwdata[15:6]) && ch3_input_select == $past(pwdata[1:0])
        ##1 ch3_test_signal_on == ch3_input_select[1])
        else $error("Configuration fields not applied.");

    dc_override_a: assert property (ch3_dc_block_override |=> !ch3_dc_block_active)
        else $error("DC blocking stayed on with the override set.");

    // Sampled reset in the antecedent keeps the release edge, where the flop still resets, out.
    dc_follow_a: assert property (presetn && !ch3_dc_block_override |=>
        ch3_dc_block_active == $past(global_dc_block_setting))
        else $error("DC blocking did not follow the global setting.");

    sel_shorted_a: assert property (presetn && ch3_input_select == 2'b01 |=>
        ch3_inputs_shorted && !ch3_pins_connected && !ch3_test_signal_on)
        else $error("Shorted input selection not routed.");

    crc_reset_a: assert property ($rose(presetn) |-> crc_q == 16'h0000)
        else $error("Checksum word is not zero after reset.");

endmodule

`default_nettype wire
